//--- src/ams_attr_buf.sv
// 512-byte attribute block store with async read
`timescale 1ns/1ps
module ams_attr_buf (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [ams_pkg::ATTR_AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [ams_pkg::ATTR_AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:(1<<ams_pkg::ATTR_AW)-1]; // attribute bytes

   // firmware fills the block
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // reader registers this value itself
   assign rd_data = mem[rd_addr];
endmodule

//--- src/ams_blk_check.sv
// legality check of a requested multi-sector block size
`timescale 1ns/1ps
module ams_blk_check (
   input wire logic [7:0] blk_size,
   output logic blk_ok
);
   logic [ams_pkg::BLK_MAX_EXP:0] hit; // one flag per power of two

   // compare against each legal power of two
   genvar i;
   generate
      for (i = 0; i <= ams_pkg::BLK_MAX_EXP; i++) begin : g_pow
         assign hit[i] = (blk_size == (8'h01 << i));
      end
   endgenerate

   // zero is legal too, it switches multi transfers off
   assign blk_ok = (|hit) || (blk_size == 8'h00);
endmodule

//--- src/ams_cmd_ctrl.sv
// task-file command interpreter: block size setup, sleep, health monitor
//
// What this block does
// - C6h sets up multi-sector block size
// - block size counts sectors per interrupt
// - size from sector count: 0,1,2,4,8,16
// - illegal size aborts, multi transfers disabled
// - size zero disables multi, no error
// - E6h or 99h enters sleep
// - sleep spins media down, interface inactive
// - media already stopped: skip spin-down
// - only soft or hard reset leaves sleep
// - B0h selects subcommand from feature register
// - D0h attrs, D1h thresholds, D2h autosave, D3h save
// - D4h off-line/self-test, D5h read log
// - attribute read: save first, send 512 bytes
`timescale 1ns/1ps
module ams_cmd_ctrl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic soft_reset,
   input wire ams_pkg::ams_tf_wr_t tf_wr,
   input wire logic rd_en,
   input wire logic [2:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic attr_wr_en,
   input wire logic [ams_pkg::ATTR_AW-1:0] attr_wr_addr,
   input wire logic [7:0] attr_wr_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data,
   input wire logic media_spinning,
   output logic spin_down_req,
   input wire logic spin_done,
   output logic save_req,
   input wire logic save_done,
   input wire logic sector_done,
   output logic block_irq,
   output logic multi_enable,
   output logic [7:0] multi_block,
   output logic intf_active,
   output ams_pkg::ams_smart_op_t smart_op
);
   ams_pkg::ams_state_t state, next_state; // interpreter state
   logic [7:0] feature_select, next_feature_select; // subcommand selector
   logic [7:0] sector_count, next_sector_count; // count / block size
   logic [7:0] sector_number, next_sector_number; // sector number
   logic [7:0] cyl_lo, next_cyl_lo; // signature low byte
   logic [7:0] cyl_hi, next_cyl_hi; // signature high byte
   logic [7:0] device_head_select, next_device_head_select; // drive select
   logic [7:0] error_flags, next_error_flags; // error register
   logic [7:0] status_flags; // composed status byte
   logic [7:0] next_rd_data; // read mux
   logic next_multi_enable; // multi transfers on
   logic [7:0] next_multi_block; // programmed block size
   logic [7:0] blk_cnt, next_blk_cnt; // sectors since last interrupt
   logic next_block_irq; // end of block
   logic next_spin_down_req; // spin-down request
   logic next_save_req; // attribute save request
   logic [ams_pkg::ATTR_AW-1:0] byte_idx, next_byte_idx; // bytes sent
   logic [7:0] next_out_data; // next byte out
   logic [7:0] buf_rd; // buffer read data
   ams_pkg::ams_smart_op_t next_smart_op; // firmware hand-off
   logic blk_ok; // requested size legal
   logic cmd_take; // command accepted this cycle
   logic sig_ok; // signature bytes match

   // attribute store
   ams_attr_buf u_attr_buf (
      .ref_clk(ref_clk),
      .wr_en(attr_wr_en),
      .wr_addr(attr_wr_addr),
      .wr_data(attr_wr_data),
      .rd_addr(next_byte_idx),
      .rd_data(buf_rd)
   );

   // block size legality
   ams_blk_check u_blk_check (
      .blk_size(sector_count),
      .blk_ok(blk_ok)
   );

   // commands only when idle and not busy
   assign cmd_take = ce && (state == ams_pkg::ST_IDLE) && tf_wr.en &&
      (tf_wr.addr == ams_pkg::TF_STAT_CMD);
   assign sig_ok = (cyl_lo == ams_pkg::SIG_CYL_LO) && (cyl_hi == ams_pkg::SIG_CYL_HI);
   assign out_valid = (state == ams_pkg::ST_SEND);
   assign intf_active = (state != ams_pkg::ST_SLEEP);

   // status byte from state and error
   always_comb begin
      status_flags = 8'h00;
      status_flags[ams_pkg::ST_BSY] = (state == ams_pkg::ST_SPIN) ||
         (state == ams_pkg::ST_SAVE) || (state == ams_pkg::ST_SEND);
      status_flags[ams_pkg::ST_RDY] = intf_active;
      status_flags[ams_pkg::ST_DSC] = intf_active;
      status_flags[ams_pkg::ST_DRQ] = (state == ams_pkg::ST_SEND);
      status_flags[ams_pkg::ST_ERR] = error_flags[ams_pkg::ER_ABT];
   end

   // next-state logic for task file and command sequencing
   always_comb begin
      next_state = state;
      next_feature_select = feature_select;
      next_sector_count = sector_count;
      next_sector_number = sector_number;
      next_cyl_lo = cyl_lo;
      next_cyl_hi = cyl_hi;
      next_device_head_select = device_head_select;
      next_error_flags = error_flags;
      next_multi_enable = multi_enable;
      next_multi_block = multi_block;
      next_spin_down_req = spin_down_req;
      next_save_req = save_req;
      next_byte_idx = byte_idx;
      next_smart_op = smart_op;
      next_smart_op.valid = 1'b0;
      // parameter writes while idle; host orders feature before command
      if ((state == ams_pkg::ST_IDLE) && tf_wr.en) begin
         case (tf_wr.addr)
            ams_pkg::TF_ERR_FEAT: next_feature_select = tf_wr.data;
            ams_pkg::TF_SECT_CNT: next_sector_count = tf_wr.data;
            ams_pkg::TF_SECT_NUM: next_sector_number = tf_wr.data;
            ams_pkg::TF_CYL_LO: next_cyl_lo = tf_wr.data;
            ams_pkg::TF_CYL_HI: next_cyl_hi = tf_wr.data;
            ams_pkg::TF_DEV_HEAD: next_device_head_select = tf_wr.data;
            default: ;
         endcase
      end
      case (state)
         ams_pkg::ST_IDLE: begin
            if (cmd_take) begin
               next_error_flags = 8'h00;
               case (tf_wr.data)
                  ams_pkg::CMD_SET_MULTI: begin
                     if (blk_ok) begin
                        next_multi_enable = (sector_count != 8'h00);
                        next_multi_block = sector_count;
                     end else begin
                        next_multi_enable = 1'b0;
                        next_error_flags[ams_pkg::ER_ABT] = 1'b1;
                     end
                  end
                  ams_pkg::CMD_SLEEP, ams_pkg::CMD_SLEEP_ALT: begin
                     if (media_spinning) begin
                        next_spin_down_req = 1'b1;
                        next_state = ams_pkg::ST_SPIN;
                     end else begin
                        next_state = ams_pkg::ST_SLEEP;
                     end
                  end
                  ams_pkg::CMD_SMART: begin
                     if (!sig_ok) begin
                        next_error_flags[ams_pkg::ER_ABT] = 1'b1;
                     end else begin
                        case (feature_select)
                           ams_pkg::SUB_READ_ATTR: begin
                              next_save_req = 1'b1;
                              next_state = ams_pkg::ST_SAVE;
                           end
                           ams_pkg::SUB_READ_THRESH, ams_pkg::SUB_AUTOSAVE,
                           ams_pkg::SUB_SAVE_ATTR, ams_pkg::SUB_OFFLINE,
                           ams_pkg::SUB_READ_LOG: begin
                              next_smart_op.valid = 1'b1;
                              next_smart_op.sub = feature_select;
                              next_smart_op.sect_cnt = sector_count;
                              next_smart_op.sect_num = sector_number;
                           end
                           default: next_error_flags[ams_pkg::ER_ABT] = 1'b1;
                        endcase
                     end
                  end
                  default: next_error_flags[ams_pkg::ER_ABT] = 1'b1;
               endcase
            end
         end
         ams_pkg::ST_SPIN: begin
            // wait for media to stop, then go quiet
            if (spin_done) begin
               next_spin_down_req = 1'b0;
               next_state = ams_pkg::ST_SLEEP;
            end
         end
         ams_pkg::ST_SAVE: begin
            // attributes stored before any byte leaves
            if (save_done) begin
               next_save_req = 1'b0;
               next_byte_idx = '0;
               next_state = ams_pkg::ST_SEND;
            end
         end
         ams_pkg::ST_SEND: begin
            // stream the attribute block byte by byte
            if (out_ready) begin
               if (byte_idx == ams_pkg::ATTR_LAST) begin
                  next_state = ams_pkg::ST_IDLE;
               end else begin
                  next_byte_idx = byte_idx + 1'b1;
               end
            end
         end
         ams_pkg::ST_SLEEP: next_state = ams_pkg::ST_SLEEP;
         default: next_state = ams_pkg::ST_IDLE;
      endcase
      // soft reset is the only way back besides the hard one
      if (soft_reset) begin
         next_state = ams_pkg::ST_IDLE;
         next_error_flags = 8'h00;
         next_spin_down_req = 1'b0;
         next_save_req = 1'b0;
         next_smart_op.valid = 1'b0;
      end
   end

   // registered read data; inactive interface reads zero
   always_comb begin
      next_rd_data = rd_data;
      if (rd_en) begin
         case (rd_addr)
            ams_pkg::TF_ERR_FEAT: next_rd_data = error_flags;
            ams_pkg::TF_SECT_CNT: next_rd_data = sector_count;
            ams_pkg::TF_SECT_NUM: next_rd_data = sector_number;
            ams_pkg::TF_CYL_LO: next_rd_data = cyl_lo;
            ams_pkg::TF_CYL_HI: next_rd_data = cyl_hi;
            ams_pkg::TF_DEV_HEAD: next_rd_data = device_head_select;
            ams_pkg::TF_STAT_CMD: next_rd_data = status_flags;
            default: next_rd_data = 8'h00;
         endcase
      end
      if (!intf_active) begin
         next_rd_data = 8'h00;
      end
   end

   // per-block interrupt pacing for multi transfers
   always_comb begin
      next_blk_cnt = blk_cnt;
      next_block_irq = 1'b0;
      next_out_data = buf_rd;
      if (cmd_take) begin
         next_blk_cnt = 8'h00;
      end else if (multi_enable && sector_done) begin
         if (blk_cnt == multi_block - 8'h01) begin
            next_blk_cnt = 8'h00;
            next_block_irq = 1'b1;
         end else begin
            next_blk_cnt = blk_cnt + 8'h01;
         end
      end
   end

   // state registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= ams_pkg::ST_IDLE;
         feature_select <= ams_pkg::TF_RST;
         sector_count <= ams_pkg::TF_RST;
         sector_number <= ams_pkg::TF_RST;
         cyl_lo <= ams_pkg::TF_RST;
         cyl_hi <= ams_pkg::TF_RST;
         device_head_select <= ams_pkg::DEV_HEAD_RST;
         error_flags <= ams_pkg::TF_RST;
         rd_data <= ams_pkg::TF_RST;
         multi_enable <= 1'b0;
         multi_block <= ams_pkg::TF_RST;
         blk_cnt <= ams_pkg::TF_RST;
         block_irq <= 1'b0;
         spin_down_req <= 1'b0;
         save_req <= 1'b0;
         byte_idx <= '0;
         out_data <= ams_pkg::TF_RST;
         smart_op <= '0;
      end else if (ce) begin
         state <= next_state;
         feature_select <= next_feature_select;
         sector_count <= next_sector_count;
         sector_number <= next_sector_number;
         cyl_lo <= next_cyl_lo;
         cyl_hi <= next_cyl_hi;
         device_head_select <= next_device_head_select;
         error_flags <= next_error_flags;
         rd_data <= next_rd_data;
         multi_enable <= next_multi_enable;
         multi_block <= next_multi_block;
         blk_cnt <= next_blk_cnt;
         block_irq <= next_block_irq;
         spin_down_req <= next_spin_down_req;
         save_req <= next_save_req;
         byte_idx <= next_byte_idx;
         out_data <= next_out_data;
         smart_op <= next_smart_op;
      end
   end

   // checks, held off while in reset or frozen
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n || !ce || soft_reset);

   sequence s_attr_take;
      cmd_take && (tf_wr.data == ams_pkg::CMD_SMART) && sig_ok &&
         (feature_select == ams_pkg::SUB_READ_ATTR);
   endsequence
   sequence s_save_wait;
      save_req && (state == ams_pkg::ST_SAVE) && !out_valid;
   endsequence

   a_multi_setup_ok:
      assert property (cmd_take && tf_wr.data == ams_pkg::CMD_SET_MULTI && blk_ok |=>
         multi_enable == ($past(sector_count) != 8'h00) &&
         multi_block == $past(sector_count) && !status_flags[ams_pkg::ST_ERR])
      else $error("block size setup not recorded");
   a_multi_bad_size:
      assert property (cmd_take && tf_wr.data == ams_pkg::CMD_SET_MULTI && !blk_ok |=>
         !multi_enable && error_flags[ams_pkg::ER_ABT] && status_flags[ams_pkg::ST_ERR] &&
         !status_flags[ams_pkg::ST_BSY])
      else $error("illegal block size not aborted");
   a_sleep_spin:
      assert property (cmd_take && (tf_wr.data == ams_pkg::CMD_SLEEP ||
         tf_wr.data == ams_pkg::CMD_SLEEP_ALT) && media_spinning |=>
         spin_down_req && state == ams_pkg::ST_SPIN)
      else $error("sleep did not spin down");
   a_sleep_skip_spin:
      assert property (cmd_take && (tf_wr.data == ams_pkg::CMD_SLEEP ||
         tf_wr.data == ams_pkg::CMD_SLEEP_ALT) && !media_spinning |=>
         !spin_down_req && !intf_active)
      else $error("spin-down not skipped");
   a_sleep_hold:
      assert property (state == ams_pkg::ST_SLEEP |=> state == ams_pkg::ST_SLEEP &&
         !intf_active && rd_data == 8'h00 ##1 !intf_active)
      else $error("sleep left without reset");
   a_sig_check:
      assert property (cmd_take && tf_wr.data == ams_pkg::CMD_SMART && !sig_ok |=>
         error_flags[ams_pkg::ER_ABT] && !smart_op.valid && !save_req)
      else $error("bad signature not aborted");
   a_save_first:
      assert property (s_attr_take |=> s_save_wait)
      else $error("attribute save not started first");
   a_send_after_save:
      assert property (state == ams_pkg::ST_SAVE && save_done |=> out_valid &&
         byte_idx == '0 && !save_req)
      else $error("attribute send did not follow save");
   a_send_length:
      assert property (out_valid && out_ready && byte_idx == ams_pkg::ATTR_LAST |=>
         !out_valid && !status_flags[ams_pkg::ST_BSY])
      else $error("attribute block length wrong");
   a_sub_dispatch:
      assert property (cmd_take && tf_wr.data == ams_pkg::CMD_SMART && sig_ok &&
         feature_select inside {[ams_pkg::SUB_READ_THRESH:ams_pkg::SUB_READ_LOG]} |=>
         smart_op.valid && smart_op.sub == $past(feature_select) ##1 !smart_op.valid)
      else $error("subcommand not dispatched");
   a_block_pace:
      assert property (multi_enable && sector_done && !cmd_take &&
         blk_cnt == multi_block - 8'h01 |=> block_irq && blk_cnt == 8'h00)
      else $error("block interrupt missing");
endmodule

//--- src/ams_pkg.sv
// shared constants, types and encodings for the command interpreter
package ams_pkg;
   // task-file register addresses
   localparam logic [2:0] TF_DATA = 3'h0;
   localparam logic [2:0] TF_ERR_FEAT = 3'h1;
   localparam logic [2:0] TF_SECT_CNT = 3'h2;
   localparam logic [2:0] TF_SECT_NUM = 3'h3;
   localparam logic [2:0] TF_CYL_LO = 3'h4;
   localparam logic [2:0] TF_CYL_HI = 3'h5;
   localparam logic [2:0] TF_DEV_HEAD = 3'h6;
   localparam logic [2:0] TF_STAT_CMD = 3'h7;
   // command codes
   localparam logic [7:0] CMD_SET_MULTI = 8'hc6;
   localparam logic [7:0] CMD_SLEEP = 8'he6;
   localparam logic [7:0] CMD_SLEEP_ALT = 8'h99;
   localparam logic [7:0] CMD_SMART = 8'hb0;
   // health-monitor subcommand codes
   localparam logic [7:0] SUB_READ_ATTR = 8'hd0;
   localparam logic [7:0] SUB_READ_THRESH = 8'hd1;
   localparam logic [7:0] SUB_AUTOSAVE = 8'hd2;
   localparam logic [7:0] SUB_SAVE_ATTR = 8'hd3;
   localparam logic [7:0] SUB_OFFLINE = 8'hd4;
   localparam logic [7:0] SUB_READ_LOG = 8'hd5;
   // signature bytes in the cylinder registers
   localparam logic [7:0] SIG_CYL_LO = 8'h4f;
   localparam logic [7:0] SIG_CYL_HI = 8'hc2;
   // status and error bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   // reset values
   localparam logic [7:0] TF_RST = 8'h00;
   localparam logic [7:0] DEV_HEAD_RST = 8'ha0;
   // block size legality: zero or a power of two up to this exponent
   localparam int BLK_MAX_EXP = 4;
   // attribute block geometry
   localparam int ATTR_AW = 9;
   localparam logic [ATTR_AW-1:0] ATTR_LAST = 9'h1ff;
   // host write into the task file
   typedef struct packed {
      logic en;
      logic [2:0] addr;
      logic [7:0] data;
   } ams_tf_wr_t;
   // subcommand hand-off to drive firmware
   typedef struct packed {
      logic valid;
      logic [7:0] sub;
      logic [7:0] sect_cnt;
      logic [7:0] sect_num;
   } ams_smart_op_t;
   // interpreter states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SPIN,
      ST_SLEEP,
      ST_SAVE,
      ST_SEND
   } ams_state_t;
endpackage

//--- tb/ams_cmd_ctrl_test.sv
// self-checking bench for the task-file command interpreter
`timescale 1ns/1ps
module ams_cmd_ctrl_test;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic soft_reset = 1'b0;
   logic attr_wr_en = 1'b0;
   logic [8:0] attr_wr_addr = 9'h000;
   logic [7:0] attr_wr_data = 8'h00;
   logic media_spinning = 1'b1;
   logic spin_done = 1'b0;
   logic save_done = 1'b0;
   logic sector_done = 1'b0;
   ams_pkg::ams_tf_wr_t tf_wr;
   ams_pkg::ams_smart_op_t smart_op;
   logic rd_en, out_valid, out_ready, spin_down_req, save_req, block_irq, multi_enable, intf_active;
   logic [2:0] rd_addr;
   logic [7:0] rd_data, out_data, multi_block, v;
   ams_pkg::ams_smart_op_t last_op = '0; // last subcommand handed on
   logic [7:0] sn; // random sector number for hand-offs
   int err_count = 0;
   int n_checks = 0;
   int irqs = 0; // block pulses seen
   int mem[512]; // reference attribute block
   int sizes[9] = '{0, 1, 2, 3, 4, 8, 16, 17, 32};
   bit ok;
   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;
   ams_cmd_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .soft_reset(soft_reset),
      .tf_wr(tf_wr), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .attr_wr_en(attr_wr_en), .attr_wr_addr(attr_wr_addr), .attr_wr_data(attr_wr_data),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .media_spinning(media_spinning), .spin_down_req(spin_down_req), .spin_done(spin_done),
      .save_req(save_req), .save_done(save_done), .sector_done(sector_done),
      .block_irq(block_irq), .multi_enable(multi_enable), .multi_block(multi_block),
      .intf_active(intf_active), .smart_op(smart_op));
   ams_host_model h (.ref_clk(ref_clk), .tf_wr(tf_wr), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
   // media and firmware acknowledge after a random wait
   always @(negedge ref_clk) begin
      spin_done <= spin_down_req && ($urandom_range(0, 3) == 0);
      save_done <= save_req && ($urandom_range(0, 3) == 0);
   end
   // count block pulses, catch subcommand hand-offs
   always @(posedge ref_clk) begin
      if (block_irq === 1'b1) irqs++;
      if (smart_op.valid === 1'b1) last_op <= smart_op;
   end
   // byte compare
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h got %h", what, exp, got);
      end
   endtask
   // status and error read-back
   task automatic stat(input logic [7:0] es, ee);
      h.rd(ams_pkg::TF_STAT_CMD, v);
      chk("status", es, v);
      h.rd(ams_pkg::TF_ERR_FEAT, v);
      chk("error", ee, v);
   endtask
   // verdict and end of run
   task automatic test_done;
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #400000;
      err_count++;
      test_done();
   end
   // main sequence
   initial begin
      void'($urandom(63467));
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      // firmware fills the attribute block
      for (int i = 0; i < 512; i++) begin
         @(negedge ref_clk);
         mem[i] = $urandom_range(0, 255);
         attr_wr_en = 1'b1;
         attr_wr_addr = i[8:0];
         attr_wr_data = mem[i][7:0];
      end
      @(negedge ref_clk);
      attr_wr_en = 1'b0;
      // block sizes, legal and not, then sector pacing
      foreach (sizes[k]) begin
         ok = sizes[k] inside {0, 1, 2, 4, 8, 16};
         h.cmd(ams_pkg::CMD_SET_MULTI, 8'h00, sizes[k][7:0], 8'h00, 8'h00, 8'h00);
         stat(ok ? 8'h50 : 8'h51, ok ? 8'h00 : 8'h04);
         chk("multi_enable", {7'h0, ok && sizes[k] != 0}, {7'h0, multi_enable});
         if (ok) chk("multi_block", sizes[k][7:0], multi_block);
         if (ok && sizes[k] != 0) begin
            irqs = 0;
            repeat (2 * sizes[k]) begin
               @(negedge ref_clk);
               sector_done = 1'b1;
               @(negedge ref_clk);
               sector_done = 1'b0;
            end
            repeat (3) @(negedge ref_clk);
            chk("block pulses", 8'h02, irqs[7:0]);
         end
      end
      // unknown command aborts
      h.cmd(8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      stat(8'h51, 8'h04);
      // health subcommands handed on
      for (int s = 1; s < 6; s++) begin
         sn = 8'($urandom_range(0, 255));
         h.cmd(ams_pkg::CMD_SMART, 8'hd0 + s[7:0], 8'h01, sn, ams_pkg::SIG_CYL_LO,
            ams_pkg::SIG_CYL_HI);
         @(negedge ref_clk);
         chk("subcommand", 8'hd0 + s[7:0], last_op.sub);
         chk("sector count", 8'h01, last_op.sect_cnt);
         chk("sector number", sn, last_op.sect_num);
         stat(8'h50, 8'h00);
      end
      // wrong signature aborts, nothing handed on
      h.cmd(ams_pkg::CMD_SMART, 8'hd1, 8'h01, 8'h06, 8'h4e, ams_pkg::SIG_CYL_HI);
      @(negedge ref_clk);
      chk("subcommand", 8'hd5, last_op.sub);
      stat(8'h51, 8'h04);
      // attribute read: save, then 512 bytes with stalls
      h.cmd(ams_pkg::CMD_SMART, ams_pkg::SUB_READ_ATTR, 8'h00, 8'h00, ams_pkg::SIG_CYL_LO,
         ams_pkg::SIG_CYL_HI);
      chk("save first", 8'h02, {6'h0, save_req, out_valid});
      for (int t = 0; t < 4000 && h.got.size() < 512; t++) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk("stream length", 8'h00, (h.got.size() == 512) ? 8'h00 : 8'hff);
      foreach (h.got[i]) chk("attr byte", mem[i][7:0], h.got[i]);
      stat(8'h50, 8'h00);
      // sleep with media turning
      h.cmd(ams_pkg::CMD_SLEEP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("spin down", 8'h01, {7'h0, spin_down_req});
      for (int t = 0; t < 100 && intf_active !== 1'b0; t++) @(negedge ref_clk);
      media_spinning = 1'b0;
      chk("asleep", 8'h00, {6'h0, intf_active, spin_down_req});
      h.wr(ams_pkg::TF_STAT_CMD, 8'h20);
      repeat (20) @(negedge ref_clk);
      chk("still asleep", 8'h00, {7'h0, intf_active});
      stat(8'h00, 8'h00);
      @(negedge ref_clk);
      soft_reset = 1'b1;
      @(negedge ref_clk);
      soft_reset = 1'b0;
      chk("awake", 8'h01, {7'h0, intf_active});
      stat(8'h50, 8'h00);
      // sleep with media stopped skips spin-down
      h.cmd(ams_pkg::CMD_SLEEP_ALT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      chk("no spin down", 8'h00, {6'h0, intf_active, spin_down_req});
      @(negedge ref_clk);
      reset_n = 1'b0;
      @(negedge ref_clk);
      reset_n = 1'b1;
      chk("awake", 8'h01, {7'h0, intf_active});
      h.rd(ams_pkg::TF_DEV_HEAD, v);
      chk("device head", ams_pkg::DEV_HEAD_RST, v);
      stat(8'h50, 8'h00);
      test_done();
   end
endmodule

//--- tb/ams_host_model.sv
// host controller model: task-file writer, reader and attribute stream sink
`timescale 1ns/1ps
module ams_host_model (
   input wire logic ref_clk,
   output ams_pkg::ams_tf_wr_t tf_wr,
   output logic rd_en,
   output logic [2:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [7:0] out_data
);
   logic [7:0] got[$]; // bytes taken from the stream
   // bus idle at time zero
   initial begin
      tf_wr = '0;
      rd_en = 1'b0;
      rd_addr = 3'h0;
      out_ready = 1'b0;
   end
   // one register write, one cycle wide
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      tf_wr = '{en: 1'b1, addr: a, data: d};
      @(negedge ref_clk);
      tf_wr.en = 1'b0;
   endtask
   // one register read, data taken a cycle later
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      d = rd_data;
   endtask
   // parameters and signature first, command code last
   task automatic cmd(input logic [7:0] c, f, n, s, lo, hi);
      wr(ams_pkg::TF_ERR_FEAT, f);
      wr(ams_pkg::TF_SECT_CNT, n);
      wr(ams_pkg::TF_SECT_NUM, s);
      wr(ams_pkg::TF_CYL_LO, lo);
      wr(ams_pkg::TF_CYL_HI, hi);
      wr(ams_pkg::TF_STAT_CMD, c);
   endtask
   // sink stalls at random
   always @(negedge ref_clk) out_ready <= ($urandom_range(0, 3) != 0);
   // collect each accepted byte
   always @(posedge ref_clk) if (out_valid && out_ready) got.push_back(out_data);
endmodule
